// ---- cpusr_regs.sv ----
// Status word and interrupt level mask registers with APB access and core-side updates
`timescale 1ns/10ps
module cpusr_regs
   import cpusr_pkg::*;
(
   input  wire logic                    CORE_CLK_IN,
   input  wire logic                    RST_IN,
   input  wire logic                    CE_IN,
   // APB slave
   input  wire logic                    PSEL_IN,
   input  wire logic                    PENABLE_IN,
   input  wire logic                    PWRITE_IN,
   input  wire logic [CPUSR_ADDR_W-1:0] PADDR_IN,
   input  wire logic [31:0]             PWDATA_IN,
   input  wire logic [3:0]              PSTRB_IN,
   output logic [31:0]                  PRDATA_OUT,
   output logic                         PREADY_OUT,
   output logic                         PSLVERR_OUT,
   // Core arithmetic port
   input  wire logic                    ALU_STB_IN,
   input  wire logic [7:0]              ALU_A_IN,
   input  wire logic [7:0]              ALU_B_IN,
   input  wire logic                    ALU_SUB_IN,
   input  wire logic                    ALU_CARRY_IN,
   output logic [7:0]                   ALU_RESULT_OUT,
   // Fast interrupt tracking
   input  wire logic                    QUICK_ISR_ENTER_IN,
   input  wire logic                    ISR_RETURN_OP_IN,
   // Interrupt levels
   input  wire logic [7:0]              LEVEL_REQUEST_IN,
   output logic [7:0]                   LEVEL_REQUEST_OUT,
   output logic [7:0]                   LEVEL_ENABLE_MASK_OUT,
   output logic [7:0]                   STATUS_WORD_OUT,
   output logic                         BANK_SEL_OUT
);

   logic [7:0]    status_word;
   logic [7:3]    arith_flags;
   logic          quick_isr_active;
   logic          bank_sel;
   logic [7:0]    level_enable_mask;
   cpusr_bus_type bus_state;
   logic [7:0]    alu_result;
   logic          f_carry;
   logic          f_zero;
   logic          f_sign;
   logic          f_ovfl;
   logic          hit_status;
   logic          hit_mask;
   logic          access;
   logic          wr_en;

   // Flag computation for the current core operation
   cpusr_flags u_flags (
      .a_in       (ALU_A_IN),
      .b_in       (ALU_B_IN),
      .sub_in     (ALU_SUB_IN),
      .carry_in   (ALU_CARRY_IN),
      .result_out (alu_result),
      .carry_out  (f_carry),
      .zero_out   (f_zero),
      .sign_out   (f_sign),
      .ovfl_out   (f_ovfl)
   );

   // Address decode
   assign hit_status = (PADDR_IN == CPUSR_STATUS_ADDR);
   assign hit_mask   = (PADDR_IN == CPUSR_MASK_ADDR);
   assign access     = PSEL_IN && PENABLE_IN && (bus_state == CPUSR_BUS_ACK) && CE_IN;
   // Only the low byte lane holds data, so only its strobe matters
   assign wr_en      = access && PWRITE_IN && PSTRB_IN[0];

   // One wait state lets read data come from a flop
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         bus_state <= CPUSR_BUS_IDLE;
      end else if (CE_IN) begin
         case (bus_state)
            CPUSR_BUS_IDLE: begin
               if (PSEL_IN && PENABLE_IN) begin
                  bus_state <= CPUSR_BUS_ACK;
               end
            end
            CPUSR_BUS_ACK: begin
               bus_state <= CPUSR_BUS_IDLE;
            end
            default: begin
               bus_state <= CPUSR_BUS_IDLE;
            end
         endcase
      end
   end

   // Handshake answers; ready drops while the clock enable freezes state
   assign PREADY_OUT  = (bus_state == CPUSR_BUS_ACK) && CE_IN;
   assign PSLVERR_OUT = PREADY_OUT && PSEL_IN && PENABLE_IN && !(hit_status || hit_mask);

   // Read data captured the cycle before the answer
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         PRDATA_OUT <= 32'h0000_0000;
      end else if (CE_IN && PSEL_IN && PENABLE_IN && (bus_state == CPUSR_BUS_IDLE)) begin
         if (hit_status) begin
            PRDATA_OUT <= {24'h00_0000, status_word};
         end else if (hit_mask) begin
            PRDATA_OUT <= {24'h00_0000, level_enable_mask};
         end else begin
            PRDATA_OUT <= 32'h0000_0000;
         end
      end
   end

   // Arithmetic flags: a core update wins over a bus write in the same cycle
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         arith_flags <= CPUSR_STATUS_RST[7:3];
      end else if (CE_IN) begin
         if (ALU_STB_IN) begin
            arith_flags[CPUSR_CARRY_POS] <= f_carry;
            arith_flags[CPUSR_ZERO_POS]  <= f_zero;
            arith_flags[CPUSR_SIGN_POS]  <= f_sign;
            arith_flags[CPUSR_OVFL_POS]  <= f_ovfl;
            arith_flags[CPUSR_ATYPE_POS] <= ALU_SUB_IN;
         end else if (wr_en && hit_status) begin
            arith_flags <= PWDATA_IN[7:3];
         end
      end
   end

   // Word assembled from separate flops; half-carry is not implemented and reads zero
   assign status_word = {arith_flags, 1'b0, quick_isr_active, bank_sel};

   // Fast service bit ignores bus writes; entry wins over a same-cycle return
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         quick_isr_active <= CPUSR_STATUS_RST[CPUSR_QISR_POS];
      end else if (CE_IN) begin
         if (QUICK_ISR_ENTER_IN) begin
            quick_isr_active <= 1'b1;
         end else if (ISR_RETURN_OP_IN) begin
            quick_isr_active <= 1'b0;
         end
      end
   end

   // Bank select bit
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         bank_sel <= CPUSR_STATUS_RST[CPUSR_BANK_POS];
      end else if (CE_IN && wr_en && hit_status) begin
         bank_sel <= PWDATA_IN[CPUSR_BANK_POS];
      end
   end

   // Level mask register
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         level_enable_mask <= CPUSR_MASK_RST;
      end else if (CE_IN && wr_en && hit_mask) begin
         level_enable_mask <= PWDATA_IN[7:0];
      end
   end

   // Result register for the core
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         ALU_RESULT_OUT <= 8'h00;
      end else if (CE_IN && ALU_STB_IN) begin
         ALU_RESULT_OUT <= alu_result;
      end
   end

   // Masked levels are removed before the core sees them
   assign LEVEL_REQUEST_OUT     = LEVEL_REQUEST_IN & level_enable_mask;
   assign LEVEL_ENABLE_MASK_OUT = level_enable_mask;
   assign STATUS_WORD_OUT       = status_word;
   assign BANK_SEL_OUT          = status_word[CPUSR_BANK_POS];

endmodule

// ---- cpusr_pkg.sv ----
// Package of offsets, field positions and reset values for the status and mask registers
package cpusr_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0]  CPUSR_STATUS_IDX   = 8'hd0;
   localparam logic [7:0]  CPUSR_MASK_IDX     = 8'hdd;
   localparam int          CPUSR_ADDR_W       = 12;
   localparam logic [11:0] CPUSR_STATUS_ADDR  = {2'h0, CPUSR_STATUS_IDX, 2'h0};
   localparam logic [11:0] CPUSR_MASK_ADDR    = {2'h0, CPUSR_MASK_IDX, 2'h0};

   // Status word field positions
   localparam int CPUSR_CARRY_POS  = 7;
   localparam int CPUSR_ZERO_POS   = 6;
   localparam int CPUSR_SIGN_POS   = 5;
   localparam int CPUSR_OVFL_POS   = 4;
   localparam int CPUSR_ATYPE_POS  = 3;
   localparam int CPUSR_HALF_POS   = 2;
   localparam int CPUSR_QISR_POS   = 1;
   localparam int CPUSR_BANK_POS   = 0;

   // Values after reset
   localparam logic [7:0] CPUSR_STATUS_RST = 8'h00;
   localparam logic [7:0] CPUSR_MASK_RST   = 8'h00;

   // Bus answer states
   typedef enum logic [1:0] {
      CPUSR_BUS_IDLE,
      CPUSR_BUS_ACK
   } cpusr_bus_type;

endpackage

// ---- cpusr_flags.sv ----
// Arithmetic unit that forms the result and the flag values of one add or subtract
`timescale 1ns/10ps
module cpusr_flags
   import cpusr_pkg::*;
(
   input  wire logic [7:0] a_in,
   input  wire logic [7:0] b_in,
   input  wire logic       sub_in,
   input  wire logic       carry_in,
   output logic [7:0]      result_out,
   output logic            carry_out,
   output logic            zero_out,
   output logic            sign_out,
   output logic            ovfl_out
);

   logic [8:0] wide;

   // Nine-bit sum or difference; bit 8 is carry out or borrow
   always_comb begin
      if (sub_in) begin
         wide = {1'b0, a_in} - {1'b0, b_in} - {8'h00, carry_in};
      end else begin
         wide = {1'b0, a_in} + {1'b0, b_in} + {8'h00, carry_in};
      end
   end

   // Flag derivation
   assign result_out = wide[7:0];
   assign carry_out  = wide[8];
   assign zero_out   = (wide[7:0] == 8'h00);
   assign sign_out   = wide[7];
   // Overflow: operand signs vs. result sign, flipped for subtract
   assign ovfl_out   = ((a_in[7] ^ b_in[7]) == sub_in) && (wide[7] != a_in[7]);

endmodule

// ---- cpusr_regs_monitor.sv ----
// Checker for status flag, fast service bit and level mask behaviour
`timescale 1ns/10ps
module cpusr_regs_monitor
   import cpusr_pkg::*;
(
   input wire logic       CORE_CLK_IN,
   input wire logic       RST_IN,
   input wire logic       CE_IN,
   input wire logic       ALU_STB_IN,
   input wire logic       ALU_SUB_IN,
   input wire logic       QUICK_ISR_ENTER_IN,
   input wire logic       ISR_RETURN_OP_IN,
   input wire logic [7:0] ALU_RESULT_OUT,
   input wire logic [7:0] LEVEL_REQUEST_IN,
   input wire logic [7:0] LEVEL_REQUEST_OUT,
   input wire logic [7:0] LEVEL_ENABLE_MASK_OUT,
   input wire logic [7:0] STATUS_WORD_OUT,
   input wire logic       BANK_SEL_OUT
);
   // One clock domain, so clocking and reset are given once
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (RST_IN);
   // Operation completion and fast service entry steps
   sequence s_alu; CE_IN && ALU_STB_IN; endsequence
   sequence s_enter; CE_IN && QUICK_ISR_ENTER_IN; endsequence
   a_zero_flag: assert property (s_alu |=> STATUS_WORD_OUT[6] == (ALU_RESULT_OUT == 8'h00))
      else $error("zero flag wrong");
   a_sign_flag: assert property (s_alu |=> STATUS_WORD_OUT[5] == ALU_RESULT_OUT[7])
      else $error("sign flag wrong");
   a_arith_type: assert property (s_alu |=> STATUS_WORD_OUT[3] == $past(ALU_SUB_IN))
      else $error("arith type wrong");
   a_bank_mirror: assert property (BANK_SEL_OUT == STATUS_WORD_OUT[0])
      else $error("bank select mismatch");
   a_mask_gate: assert property (LEVEL_REQUEST_OUT == (LEVEL_REQUEST_IN & LEVEL_ENABLE_MASK_OUT))
      else $error("masked level passed");
   a_quick_enter: assert property (s_enter |=> STATUS_WORD_OUT[1])
      else $error("fast bit not set");
   a_quick_leave: assert property (CE_IN && ISR_RETURN_OP_IN && !QUICK_ISR_ENTER_IN
      |=> !STATUS_WORD_OUT[1]) else $error("fast bit not cleared");
   a_quick_hold: assert property (CE_IN && !QUICK_ISR_ENTER_IN && !ISR_RETURN_OP_IN
      |=> $stable(STATUS_WORD_OUT[1])) else $error("fast bit changed");
endmodule

bind cpusr_regs cpusr_regs_monitor mon_u (.*);

// ---- tb.sv ----
// Testbench for the status word and level mask registers
`timescale 1ns/10ps
module tb
   import cpusr_pkg::*;
;
   logic        clk, rst, ce, psel, pen, pwr, stb, sub, cin, qe, qr, pready, perr, bank, errv;
   logic [7:0]  a, b, lreq, res, lout, mask, sw;
   logic [3:0]  pstrb;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   int          errors, num_checks;

   cpusr_regs dut_u (.CORE_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(perr), .ALU_STB_IN(stb), .ALU_A_IN(a), .ALU_B_IN(b),
      .ALU_SUB_IN(sub), .ALU_CARRY_IN(cin), .ALU_RESULT_OUT(res), .QUICK_ISR_ENTER_IN(qe),
      .ISR_RETURN_OP_IN(qr), .LEVEL_REQUEST_IN(lreq), .LEVEL_REQUEST_OUT(lout),
      .LEVEL_ENABLE_MASK_OUT(mask), .STATUS_WORD_OUT(sw), .BANK_SEL_OUT(bank));

   // Compare and count, unknowns never match
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // One bus transfer; the first edge keeps two transfers from colliding in one step
   task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] d, input logic [3:0] s);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= ad;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      // Ready, read data and error are all taken at the rising edge that ends the access
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 9);
      if (pready !== 1'b1) begin
         errors++;
         end_of_test();
      end
      rdv = prdata;
      errv = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   // Expected flags worked out here; bank bit is held at 1 around these calls
   task automatic alu(input logic [7:0] x, input logic [7:0] y, input logic s, input logic c);
      logic [8:0] r;
      logic [7:0] e;
      r = s ? {1'b0, x} - {1'b0, y} - 9'(c) : {1'b0, x} + {1'b0, y} + 9'(c);
      e = {r[8], r[7:0] == 8'h00, r[7], (x[7] ^ r[7]) & (x[7] ^ y[7] ^ !s), s, 3'h1};
      @(posedge clk);
      stb <= 1'b1;
      a <= x;
      b <= y;
      sub <= s;
      cin <= c;
      @(posedge clk);
      stb <= 1'b0;
      @(negedge clk);
      chk(res, r[7:0]);
      chk(sw, e);
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      {rst, ce, psel, pen, pwr, stb, sub, cin, qe, qr} = 10'h300;
      {a, b, lreq, pstrb, paddr, pwdata} = '0;
      errors = 0;
      num_checks = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      lreq <= 8'hff;
      apb(1'b0, CPUSR_STATUS_ADDR, 8'h00, 4'h0);
      chk(rdv, 32'h0);
      apb(1'b1, CPUSR_STATUS_ADDR, 8'hff, 4'h1);
      apb(1'b0, CPUSR_STATUS_ADDR, 8'h00, 4'h0);
      chk(rdv, 32'hf9);
      // Walk one enabled level at a time, all levels requesting
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, CPUSR_MASK_ADDR, 8'h01 << i, 4'h1);
         apb(1'b0, CPUSR_MASK_ADDR, 8'h00, 4'h0);
         chk(rdv, 32'h1 << i);
         chk(lout, 8'h01 << i);
      end
      apb(1'b1, CPUSR_MASK_ADDR, 8'h7f, 4'h0);
      apb(1'b0, CPUSR_MASK_ADDR, 8'h00, 4'h0);
      chk(rdv, 32'h80);
      apb(1'b0, 12'h004, 8'h00, 4'h0);
      chk(errv, 1'b1);
      apb(1'b1, CPUSR_STATUS_ADDR, 8'h01, 4'h1);
      alu(8'h7f, 8'h01, 1'b0, 1'b0);
      alu(8'hff, 8'h00, 1'b0, 1'b1);
      alu(8'h00, 8'h01, 1'b1, 1'b0);
      alu(8'h80, 8'h01, 1'b1, 1'b0);
      alu(8'h05, 8'h04, 1'b1, 1'b1);
      // Fast bit survives a bus write, then falls on return
      @(posedge clk);
      qe <= 1'b1;
      @(posedge clk);
      qe <= 1'b0;
      apb(1'b1, CPUSR_STATUS_ADDR, 8'h00, 4'h1);
      apb(1'b0, CPUSR_STATUS_ADDR, 8'h00, 4'h0);
      chk(rdv, 32'h2);
      @(posedge clk);
      qr <= 1'b1;
      @(posedge clk);
      qr <= 1'b0;
      @(negedge clk);
      chk(sw, 8'h00);
      // Clock enable low: a strobed operation must leave flags and result alone
      ce <= 1'b0;
      stb <= 1'b1;
      a <= 8'h01;
      b <= 8'h01;
      sub <= 1'b0;
      cin <= 1'b0;
      @(posedge clk);
      stb <= 1'b0;
      ce <= 1'b1;
      @(negedge clk);
      chk(sw, 8'h00);
      chk(res, 8'h00);
      end_of_test();
   end
endmodule
